// *** core/tcc_port.sv ***
// What this block does
// - After enable or restart the port runs as a dual-role port.
// - Dual-role toggles between pull-ups on both lines and pull-downs on both.
// - As source, find sink termination; in attached source drive attach pin low.
// - Sink found with Ra on the other line: cable supply onto that line.
// - Source advertises default, then the software-selected higher level.
// - GPIO mode advertises only the default level.
// - As sink, debounce line levels and wait for bus supply before attaching.
// - Attached sink reports partner current on code pins or detect field.
// - Role preferences only in I2C mode; GPIO mode is plain dual-role.
// - Preference field 2'b11 makes the port try to attach as source.
// - Default advertisement 500/900 mA; field selects 1.5 A or 3 A.
// - GPIO mode: audio pin low while audio accessory present.
// - Both lines below Ra means a passive audio adapter.
// - As source, sink pull-downs on both lines mean a debug accessory.
// - As sink, pull-ups on both lines give accessory type 3'b111.
// - Floating select pin gives GPIO mode, driven high or low I2C mode.
// - All pins are open drain: drive low or release.
// - GPIO mode code pins: HH unattached, HL default, LH medium, LL high current.
// - I2C mode: interrupt pin low when new information is stored.
// - Change flag set with interrupt; software clears it by a write.
// - Bus supply decides sink attach/detach, debug accessory exit as sink and role.
// - Enable pin falling or soft restart returns to dual-role.
`timescale 1ns/1ns
`default_nettype none
module tcc_port
   import tcc_pkg::*;
#(
   parameter int SRC_T = SRC_CYC,
   parameter int SNK_T = SNK_CYC,
   parameter int DB_T  = CC_DB_CYC,
   parameter int VB_T  = VBUS_DB_CYC,
   parameter int TRY_T = TRY_CYC
) (
   input  wire logic     ref_clk,
   input  wire logic     rst_b,
   input  wire logic     enable_b,
   input  wire logic     soft_reset,
   input  wire logic     bus_sel_float,
   input  wire logic     vbus_det,
   input  wire tcc_cc_t  cc1_level,
   input  wire tcc_cc_t  cc2_level,
   input  wire logic [1:0] role_preference_field,
   input  wire tcc_cur_t adv_current,
   input  wire logic     change_clear,
   output var  logic     cc_pullup_en,
   output var  logic     cc_pulldown_en,
   output var  tcc_cur_t rp_level,
   output var  logic     vconn_cc1_en,
   output var  logic     vconn_cc2_en,
   output var  logic     attach_indicator_pin_oe_b,
   output var  logic     current_code_pin_a_oe_b,
   output var  logic     current_code_pin_b_oe_b,
   output var  logic     audio_accessory_pin_oe_b,
   output var  logic     i2c_mode,
   output var  logic     attached_src,
   output var  logic     attached_snk,
   output var  tcc_cur_t cur_detect,
   output var  logic [2:0] accessory_type,
   output var  logic     change_flag
);
   logic [SYNC_W-1:0] sync_q;
   tcc_cc_t    cc1_s;
   tcc_cc_t    cc2_s;
   logic       vb_s;
   logic       en_s;
   logic       float_s;
   tcc_cc_t    cc1_db_r;
   tcc_cc_t    cc2_db_r;
   logic [5:0] cc_cand_r;
   logic [CNT_W-1:0] cc_cnt_r;
   logic       vb_cand_r;
   logic       vb_db_r;
   logic [CNT_W-1:0] vb_cnt_r;
   tcc_state_t st_r;
   tcc_state_t st_nxt;
   logic [CNT_W-1:0] tmr_r;
   logic       tried_r;
   logic       dbg_snk_r;
   logic       cc_sel_r;
   logic       restart;
   logic       gpio;
   logic       evt;
   tcc_cur_t   cur_c;

   function automatic logic is_rp(tcc_cc_t c);
      return c == CC_RP_DEF || c == CC_RP_MED || c == CC_RP_HIGH;
   endfunction

   function automatic logic is_att(tcc_state_t s);
      return s == ST_ATT_SNK || s == ST_ATT_SRC || s == ST_AUDIO || s == ST_DEBUG;
   endfunction

   function automatic tcc_cur_t rp_cur(tcc_cc_t c);
      return c == CC_RP_HIGH ? CUR_HIGH : (c == CC_RP_MED ? CUR_MED : CUR_DEF);
   endfunction

   tcc_sync #(.W(SYNC_W)) u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .d       ({cc1_level, cc2_level, vbus_det, enable_b, bus_sel_float}),
      .q       (sync_q)
   );

   assign cc1_s   = tcc_cc_t'(sync_q[8:6]);
   assign cc2_s   = tcc_cc_t'(sync_q[5:3]);
   assign vb_s    = sync_q[2];
   assign en_s    = sync_q[1];
   assign float_s = sync_q[0];
   assign gpio    = float_s;
   assign restart = en_s || soft_reset;

   // Line codes accepted only after a full quiet interval
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cc_cand_r <= '0;
         cc_cnt_r  <= '0;
         cc1_db_r  <= CC_OPEN;
         cc2_db_r  <= CC_OPEN;
      end
      else if ({cc1_s, cc2_s} != cc_cand_r)
      begin
         cc_cand_r <= {cc1_s, cc2_s};
         cc_cnt_r  <= '0;
      end
      else if (cc_cnt_r >= CNT_W'(DB_T - 1))
      begin
         cc1_db_r <= tcc_cc_t'(cc_cand_r[5:3]);
         cc2_db_r <= tcc_cc_t'(cc_cand_r[2:0]);
      end
      else
         cc_cnt_r <= cc_cnt_r + 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         vb_cand_r <= 1'b0;
         vb_cnt_r  <= '0;
         vb_db_r   <= 1'b0;
      end
      else if (vb_s != vb_cand_r)
      begin
         vb_cand_r <= vb_s;
         vb_cnt_r  <= '0;
      end
      else if (vb_cnt_r >= CNT_W'(VB_T - 1))
         vb_db_r <= vb_cand_r;
      else
         vb_cnt_r <= vb_cnt_r + 1'b1;
   end

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         ST_UNATT_SNK:
            if (is_rp(cc1_s) || is_rp(cc2_s))
               st_nxt = ST_WAIT_SNK;
            else if (tmr_r >= CNT_W'(SNK_T - 1))
               st_nxt = ST_UNATT_SRC;
         ST_WAIT_SNK:
            if (is_rp(cc1_db_r) && is_rp(cc2_db_r) && vb_db_r)
               st_nxt = ST_DEBUG;
            else if ((is_rp(cc1_db_r) || is_rp(cc2_db_r)) && vb_db_r)
               st_nxt = (!gpio && !tried_r && role_preference_field == PREF_TRY_SRC) ? ST_TRY_SRC : ST_ATT_SNK;
            else if (!is_rp(cc1_s) && !is_rp(cc2_s) && !is_rp(cc1_db_r) && !is_rp(cc2_db_r)
                     && tmr_r >= CNT_W'(DB_T - 1))
               st_nxt = ST_UNATT_SRC;
         ST_ATT_SNK:
            if (!vb_db_r)
               st_nxt = ST_UNATT_SNK;
         ST_TRY_SNK:
            if ((is_rp(cc1_db_r) || is_rp(cc2_db_r)) && vb_db_r)
               st_nxt = ST_ATT_SNK;
            else if (tmr_r >= CNT_W'(TRY_T - 1))
               st_nxt = ST_WAIT_SRC;
         ST_UNATT_SRC:
            if (cc1_s == CC_RD || cc2_s == CC_RD || (cc1_s == CC_AUD && cc2_s == CC_AUD))
               st_nxt = ST_WAIT_SRC;
            else if (tmr_r >= CNT_W'(SRC_T - 1))
               st_nxt = ST_UNATT_SNK;
         ST_WAIT_SRC:
            if (cc1_db_r == CC_RD && cc2_db_r == CC_RD)
               st_nxt = ST_DEBUG;
            else if (cc1_db_r == CC_AUD && cc2_db_r == CC_AUD)
               st_nxt = ST_AUDIO;
            else if (cc1_db_r == CC_RD || cc2_db_r == CC_RD)
               st_nxt = (!gpio && !tried_r && role_preference_field == PREF_TRY_SNK) ? ST_TRY_SNK : ST_ATT_SRC;
            else if (cc1_s == CC_OPEN && cc2_s == CC_OPEN && cc1_db_r == CC_OPEN && cc2_db_r == CC_OPEN
                     && tmr_r >= CNT_W'(DB_T - 1))
               st_nxt = ST_UNATT_SNK;
         ST_ATT_SRC:
            if (cc1_db_r != CC_RD && cc2_db_r != CC_RD)
               st_nxt = ST_UNATT_SNK;
         ST_TRY_SRC:
            if (cc1_db_r == CC_RD || cc2_db_r == CC_RD)
               st_nxt = ST_ATT_SRC;
            else if (tmr_r >= CNT_W'(TRY_T - 1))
               st_nxt = ST_WAIT_SNK;
         ST_AUDIO:
            if (cc1_db_r != CC_AUD || cc2_db_r != CC_AUD)
               st_nxt = ST_UNATT_SNK;
         ST_DEBUG:
            if (dbg_snk_r ? !vb_db_r : (cc1_db_r != CC_RD || cc2_db_r != CC_RD))
               st_nxt = ST_UNATT_SNK;
         default:
            st_nxt = ST_UNATT_SNK;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r    <= ST_UNATT_SNK;
         tmr_r   <= '0;
         tried_r <= 1'b0;
      end
      else if (restart)
      begin
         st_r    <= ST_UNATT_SNK;
         tmr_r   <= '0;
         tried_r <= 1'b0;
      end
      else
      begin
         st_r  <= st_nxt;
         tmr_r <= (st_nxt != st_r) ? '0 : (tmr_r == '1 ? tmr_r : tmr_r + 1'b1);
         // A failed try must not loop back into another try
         if (st_nxt == ST_TRY_SRC || st_nxt == ST_TRY_SNK)
            tried_r <= 1'b1;
         else if (st_nxt == ST_UNATT_SNK || st_nxt == ST_UNATT_SRC)
            tried_r <= 1'b0;
      end
   end

   // Which line carries the partner, fixed on entry to attach
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cc_sel_r  <= 1'b0;
         dbg_snk_r <= 1'b0;
      end
      else if (!restart && st_nxt != st_r && is_att(st_nxt))
      begin
         cc_sel_r  <= (st_nxt == ST_ATT_SNK) ? !is_rp(cc1_db_r) : (cc1_db_r != CC_RD);
         dbg_snk_r <= (st_r == ST_WAIT_SNK);
      end
   end

   assign cur_c = rp_cur(cc_sel_r ? cc2_db_r : cc1_db_r);
   assign evt   = !restart && st_nxt != st_r && (is_att(st_nxt) || is_att(st_r));

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cc_pullup_en   <= 1'b0;
         cc_pulldown_en <= 1'b1;
         rp_level       <= CUR_DEF;
         vconn_cc1_en   <= 1'b0;
         vconn_cc2_en   <= 1'b0;
         attached_src   <= 1'b0;
         attached_snk   <= 1'b0;
         i2c_mode       <= 1'b0;
      end
      else
      begin
         cc_pullup_en   <= st_r == ST_UNATT_SRC || st_r == ST_WAIT_SRC || st_r == ST_ATT_SRC
                           || st_r == ST_TRY_SRC || st_r == ST_AUDIO || (st_r == ST_DEBUG && !dbg_snk_r);
         cc_pulldown_en <= !(st_r == ST_UNATT_SRC || st_r == ST_WAIT_SRC || st_r == ST_ATT_SRC
                           || st_r == ST_TRY_SRC || st_r == ST_AUDIO || (st_r == ST_DEBUG && !dbg_snk_r));
         // Default Rp serves both 500 mA and 900 mA ports
         rp_level       <= (gpio || adv_current == CUR_NONE) ? CUR_DEF : adv_current;
         vconn_cc1_en   <= st_r == ST_ATT_SRC && cc_sel_r && cc1_db_r == CC_RA;
         vconn_cc2_en   <= st_r == ST_ATT_SRC && !cc_sel_r && cc2_db_r == CC_RA;
         attached_src   <= st_r == ST_ATT_SRC;
         attached_snk   <= st_r == ST_ATT_SNK;
         i2c_mode       <= !gpio;
      end
   end

   // Pins only ever pull low; a released pin reads high
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         attach_indicator_pin_oe_b <= 1'b1;
         current_code_pin_a_oe_b   <= 1'b1;
         current_code_pin_b_oe_b   <= 1'b1;
         audio_accessory_pin_oe_b  <= 1'b1;
      end
      else
      begin
         attach_indicator_pin_oe_b <= st_r != ST_ATT_SRC;
         current_code_pin_a_oe_b   <= !(gpio && st_r == ST_ATT_SNK && (cur_c == CUR_MED || cur_c == CUR_HIGH));
         current_code_pin_b_oe_b   <= !(gpio && st_r == ST_ATT_SNK && (cur_c == CUR_DEF || cur_c == CUR_HIGH));
         audio_accessory_pin_oe_b  <= gpio ? st_r != ST_AUDIO : !change_flag;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cur_detect     <= CUR_NONE;
         accessory_type <= ACC_NONE;
      end
      else
      begin
         cur_detect <= st_r == ST_ATT_SNK ? cur_c : CUR_NONE;
         if (st_r == ST_AUDIO)
            accessory_type <= ACC_AUDIO;
         else if (st_r == ST_DEBUG)
            accessory_type <= dbg_snk_r ? ACC_DBG_SRC : ACC_DBG_SNK;
         else
            accessory_type <= ACC_NONE;
      end
   end

   // New event wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         change_flag <= 1'b0;
      else if (evt && !gpio)
         change_flag <= 1'b1;
      else if (change_clear || gpio)
         change_flag <= 1'b0;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   restart_drp_a: assert property (restart |=> st_r == ST_UNATT_SNK)
      else $error("restart did not return to unattached sink");
   pull_excl_a: assert property (cc_pullup_en != cc_pulldown_en)
      else $error("pull-up and pull-down not exclusive");
   attach_pin_a: assert property (st_r == ST_ATT_SRC |=> !attach_indicator_pin_oe_b)
      else $error("attach pin not low in attached source");
   gpio_rp_a: assert property (gpio && $past(gpio) |-> rp_level == CUR_DEF)
      else $error("higher current advertised in gpio mode");
   gpio_try_a: assert property (gpio |=> st_r != ST_TRY_SRC && st_r != ST_TRY_SNK)
      else $error("role try entered in gpio mode");
   snk_vbus_a: assert property (st_r != ST_ATT_SNK ##1 st_r == ST_ATT_SNK |-> $past(vb_db_r))
      else $error("sink attached without bus supply");
   vconn_src_a: assert property (vconn_cc1_en || vconn_cc2_en |-> $past(st_r) == ST_ATT_SRC)
      else $error("cable supply outside attached source");
   flag_set_a: assert property (evt && !gpio |=> change_flag ##1 !audio_accessory_pin_oe_b)
      else $error("change flag or interrupt missing");
   audio_pin_a: assert property (gpio && st_r == ST_AUDIO |=> !audio_accessory_pin_oe_b)
      else $error("audio pin not low");
   code_idle_a: assert property (st_r != ST_ATT_SNK
                                 |=> current_code_pin_a_oe_b && current_code_pin_b_oe_b)
      else $error("code pins not released when unattached");
endmodule
`default_nettype wire

// *** shared/tcc_pkg.sv ***
`default_nettype none
package tcc_pkg;
   localparam int CLK_MHZ      = 100;
   localparam int PCT_FULL     = 100;
   localparam int T_DRP_US     = 75000;
   localparam int DRP_SRC_PCT  = 30;
   localparam int T_CC_DB_US   = 168000;
   localparam int T_VBUS_DB_US = 2000;
   localparam int T_TRY_US     = 100000;
   localparam int CNT_W        = 32;
   localparam int SRC_CYC      = T_DRP_US * CLK_MHZ / PCT_FULL * DRP_SRC_PCT;
   localparam int SNK_CYC      = T_DRP_US * CLK_MHZ / PCT_FULL * (PCT_FULL - DRP_SRC_PCT);
   localparam int CC_DB_CYC    = T_CC_DB_US * CLK_MHZ;
   localparam int VBUS_DB_CYC  = T_VBUS_DB_US * CLK_MHZ;
   localparam int TRY_CYC      = T_TRY_US * CLK_MHZ;
   localparam int SYNC_W       = 9;

   typedef enum logic [2:0] {CC_OPEN, CC_AUD, CC_RA, CC_RD, CC_RP_DEF, CC_RP_MED, CC_RP_HIGH} tcc_cc_t;
   typedef enum logic [1:0] {CUR_NONE, CUR_DEF, CUR_MED, CUR_HIGH} tcc_cur_t;
   typedef enum logic [3:0] {ST_UNATT_SNK, ST_WAIT_SNK, ST_ATT_SNK, ST_TRY_SNK, ST_UNATT_SRC,
                             ST_WAIT_SRC, ST_ATT_SRC, ST_TRY_SRC, ST_AUDIO, ST_DEBUG} tcc_state_t;

   localparam logic [1:0] PREF_TRY_SRC = 2'h3;
   localparam logic [1:0] PREF_TRY_SNK = 2'h1;
   localparam logic [2:0] ACC_NONE     = 3'h0;
   localparam logic [2:0] ACC_AUDIO    = 3'h4;
   localparam logic [2:0] ACC_DBG_SNK  = 3'h6;
   localparam logic [2:0] ACC_DBG_SRC  = 3'h7;
endpackage
`default_nettype wire

// *** core/tcc_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcc_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A bit moves only once the last two stages agree
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
               q[i] <= 1'b0;
            else if (s2_r[i] == s3_r[i])
               q[i] <= s3_r[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** tb/tcc_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcc_partner
   import tcc_pkg::*;
(
   input  wire logic [2:0] mode,
   input  wire tcc_cc_t    rp_code,
   input  wire logic       ra_cc2,
   input  wire logic       vbus_on,
   input  wire logic       dut_pullup,
   input  wire logic       dut_pulldown,
   output var  tcc_cc_t    cc1_level,
   output var  tcc_cc_t    cc2_level,
   output var  logic       vbus_det
);
   // Modes: 0 none, 1 sink, 2 source, 3 audio adapter, 4 debug with Rd, 5 debug with Rp
   always_comb
   begin
      cc1_level = CC_OPEN;
      cc2_level = CC_OPEN;
      case (mode)
         3'h1:
         begin
            // Rd and Ra only show against our pull-ups
            if (dut_pullup)
            begin
               cc1_level = CC_RD;
               cc2_level = ra_cc2 ? CC_RA : CC_OPEN;
            end
         end
         3'h2:
            if (dut_pulldown)
               cc1_level = rp_code;
         3'h3:
         begin
            cc1_level = CC_AUD;
            cc2_level = CC_AUD;
         end
         3'h4:
            if (dut_pullup)
            begin
               cc1_level = CC_RD;
               cc2_level = CC_RD;
            end
         3'h5:
            if (dut_pulldown)
            begin
               cc1_level = rp_code;
               cc2_level = rp_code;
            end
         default:
            cc1_level = CC_OPEN;
      endcase
   end

   // Only source-like partners supply the bus
   assign vbus_det = vbus_on && (mode == 3'h2 || mode == 3'h5);
endmodule
`default_nettype wire

// *** tb/tb_tcc_port.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
`define WAITC(c) begin for (wcnt = 0; wcnt < 400 && !(c); wcnt++) @(negedge ref_clk); \
   if (!(c)) begin num_errors++; $display("unexpected timeout at %0t", $time); end_sim(); end end
module tb_tcc_port
   import tcc_pkg::*;
();
   logic       ref_clk = 1'b0, rst_b = 1'b0, enable_b = 1'b0, soft_reset = 1'b0;
   logic       bus_sel_float = 1'b1, change_clear = 1'b0, vbus_det;
   logic [1:0] role_preference_field = 2'h0;
   tcc_cur_t   adv_current = CUR_NONE;
   tcc_cc_t    cc1_level, cc2_level;
   logic [2:0] p_mode = 3'h0;
   tcc_cc_t    p_rp = CC_RP_DEF;
   logic       p_ra = 1'b0, p_vbus = 1'b0;
   logic       pu, pd, vc1, vc2, att_b, cod_a_b, cod_b_b, aud_b, i2c_mode, att_src, att_snk, change_flag;
   tcc_cur_t   rp_level, cur_detect;
   logic [2:0] accessory_type;
   int         num_errors = 0, num_checks = 0, wcnt;

   // Short counts keep the run brief
   tcc_port #(.SRC_T(20), .SNK_T(40), .DB_T(8), .VB_T(4), .TRY_T(60)) i_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .enable_b(enable_b), .soft_reset(soft_reset),
      .bus_sel_float(bus_sel_float), .vbus_det(vbus_det), .cc1_level(cc1_level), .cc2_level(cc2_level),
      .role_preference_field(role_preference_field), .adv_current(adv_current),
      .change_clear(change_clear), .cc_pullup_en(pu), .cc_pulldown_en(pd), .rp_level(rp_level),
      .vconn_cc1_en(vc1), .vconn_cc2_en(vc2), .attach_indicator_pin_oe_b(att_b),
      .current_code_pin_a_oe_b(cod_a_b), .current_code_pin_b_oe_b(cod_b_b),
      .audio_accessory_pin_oe_b(aud_b), .i2c_mode(i2c_mode), .attached_src(att_src),
      .attached_snk(att_snk), .cur_detect(cur_detect), .accessory_type(accessory_type),
      .change_flag(change_flag));

   tcc_partner i_partner (
      .mode(p_mode), .rp_code(p_rp), .ra_cc2(p_ra), .vbus_on(p_vbus), .dut_pullup(pu),
      .dut_pulldown(pd), .cc1_level(cc1_level), .cc2_level(cc2_level), .vbus_det(vbus_det));

   always #5 ref_clk = ~ref_clk;

   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic go_idle;
      p_mode = 3'h0;
      p_vbus = 1'b0;
      p_ra = 1'b0;
      `WAITC(!att_snk && !att_src && accessory_type == ACC_NONE)
      settle(3);
      `CHK("vconn_cc2", 1'b0, vc2)
      `CHK("attach_pin", 1'b1, att_b)
      `CHK("code_a", 1'b1, cod_a_b)
      `CHK("code_b", 1'b1, cod_b_b)
   endtask

   task automatic t_reset;
      `CHK("pulldown", 1'b1, pd)
      `CHK("pullup", 1'b0, pu)
      `CHK("attach_pin", 1'b1, att_b)
      `CHK("audio_pin", 1'b1, aud_b)
      `CHK("code_pins", 2'b11, {cod_a_b, cod_b_b})
      `CHK("vconn", 2'b00, {vc1, vc2})
      `CHK("i2c_mode", 1'b0, i2c_mode)
   endtask

   task automatic t_toggle;
      `WAITC(pu)
      `CHK("pulldown_in_src", 1'b0, pd)
      `WAITC(pd)
      `CHK("pullup_in_snk", 1'b0, pu)
   endtask

   task automatic t_sink(input tcc_cc_t rp, input tcc_cur_t c, input logic a, input logic b);
      // Preference set on purpose: GPIO mode must ignore it
      role_preference_field = PREF_TRY_SRC;
      p_rp = rp;
      p_mode = 3'h2;
      settle(150);
      // No bus supply yet, so no attach may happen
      `CHK("attached_snk_no_vbus", 1'b0, att_snk)
      p_vbus = 1'b1;
      `WAITC(att_snk)
      settle(2);
      `CHK("cur_detect", c, cur_detect)
      `CHK("code_a", a, cod_a_b)
      `CHK("code_b", b, cod_b_b)
      go_idle();
      role_preference_field = 2'h0;
   endtask

   task automatic t_try(input logic [1:0] pref, input logic [2:0] m, input logic src);
      int n;
      int run;
      n = 0;
      run = 0;
      bus_sel_float = 1'b0;
      role_preference_field = pref;
      p_rp = CC_RP_DEF;
      p_vbus = 1'b1;
      p_mode = m;
      // A try shows as one long stretch of the other termination
      for (wcnt = 0; wcnt < 400 && !(src ? att_src : att_snk); wcnt++)
      begin
         @(negedge ref_clk);
         run = (src ? pd : pu) ? run + 1 : 0;
         n = (run > n) ? run : n;
      end
      `WAITC(src ? att_src : att_snk)
      `CHK("try_stretch", 1'b1, n > 50)
      `CHK("attached_other_role", 1'b0, src ? att_snk : att_src)
      go_idle();
      role_preference_field = 2'h0;
   endtask

   task automatic t_source(input logic i2c);
      bus_sel_float = !i2c;
      adv_current = CUR_HIGH;
      settle(8);
      `CHK("i2c_mode", i2c, i2c_mode)
      p_ra = 1'b1;
      p_mode = 3'h1;
      `WAITC(att_src)
      settle(2);
      `CHK("attach_pin", 1'b0, att_b)
      `CHK("vconn", 2'b01, {vc1, vc2})
      `CHK("rp_level", i2c ? CUR_HIGH : CUR_DEF, rp_level)
      `CHK("change_flag", i2c, change_flag)
      `CHK("int_pin", !i2c, aud_b)
      if (i2c)
      begin
         change_clear = 1'b1;
         settle(1);
         change_clear = 1'b0;
         settle(2);
         `CHK("change_flag_cleared", 1'b0, change_flag)
         `CHK("int_pin_released", 1'b1, aud_b)
      end
      go_idle();
   endtask

   task automatic t_acc(input logic [2:0] m, input logic v, input logic [2:0] e, input logic pin);
      p_rp = CC_RP_DEF;
      p_vbus = v;
      p_mode = m;
      `WAITC(accessory_type != ACC_NONE)
      settle(2);
      `CHK("accessory_type", e, accessory_type)
      `CHK("audio_pin", pin, aud_b)
      go_idle();
      `CHK("audio_pin_released", 1'b1, aud_b)
   endtask

   task automatic t_restart;
      int n;
      n = 0;
      p_mode = 3'h1;
      `WAITC(att_src)
      soft_reset = 1'b1;
      settle(1);
      soft_reset = 1'b0;
      settle(2);
      `CHK("attached_src_after_restart", 1'b0, att_src)
      `CHK("pulldown_after_restart", 1'b1, pd)
      enable_b = 1'b1;
      settle(8);
      // Disabled port must sit on pull-downs, never toggling
      repeat (100)
      begin
         @(negedge ref_clk);
         n += pu;
      end
      `CHK("pullup_while_disabled", 0, n)
      enable_b = 1'b0;
      go_idle();
   endtask

   initial
   begin
      repeat (20) @(negedge ref_clk);
      t_reset();
      rst_b = 1'b1;
      settle(6);
      t_reset();
      t_toggle();
      t_sink(CC_RP_DEF, CUR_DEF, 1'b1, 1'b0);
      t_sink(CC_RP_MED, CUR_MED, 1'b0, 1'b1);
      t_sink(CC_RP_HIGH, CUR_HIGH, 1'b0, 1'b0);
      t_source(1'b0);
      t_acc(3'h3, 1'b0, ACC_AUDIO, 1'b0);
      t_acc(3'h4, 1'b0, ACC_DBG_SNK, 1'b1);
      t_acc(3'h5, 1'b1, ACC_DBG_SRC, 1'b1);
      t_source(1'b1);
      t_try(PREF_TRY_SRC, 3'h2, 1'b0);
      t_try(PREF_TRY_SNK, 3'h1, 1'b1);
      t_restart();
      end_sim();
   end
endmodule
`default_nettype wire
